// [hw/ccc_config_reg.v]
// Configuration and cache-control register of the system coprocessor.
// Assumes move-to/move-from strobes are synchronous to sys_clk.
// Functional notes
// RL1: Register is coprocessor register number 16.
// RL2: Reset clears all bits to zero.
// RL3: Bit 18 gates external bus-master grant.
// RL4: Bits 17,16 enable icache sets 0,1.
// RL5: Bits 15:14 select icache set size.
// RL6: Bits 13,12 enable dcache sets 0,1.
// RL7: Bits 11:10 select dcache set size.
// RL8: Bit 9 enables in-page write.
// RL9: Bits 8:7 select in-page write size.
// RL10: Bit 6 enables TLB translation.
// RL11: Bit 5 selects unmapped writeback policy.
// RL12: Bits 4,3 select dcache scratchpad mode.
// RL13: Bit 2 isolates cache from memory.
// RL14: Bit 1 routes accesses to tag RAMs.
// RL15: Bit 0 enables cache invalidate mode.
// RL16: Software invalidates all tags before enabling.
// RL17: Bits 31:28 read zero; 27:19 plain storage.
// RL18: Writes effective next cycle; reads current.
`default_nettype none
`include "ccc_defs.vh"
module ccc_config_reg (
  input  wire        sys_clk,
  input  wire        rst_n,
  input  wire        cop_wr_en,
  input  wire        cop_rd_en,
  input  wire [4:0]  cop_reg_num,
  input  wire [31:0] cop_wr_data,
  output reg  [31:0] cop_rd_data,
  input  wire        ext_master_req,
  output wire        ext_master_grant,
  output wire        ext_master_grant_en,
  output wire        icache_set0_en,
  output wire        icache_set1_en,
  output wire [1:0]  icache_set_size,
  output wire [3:0]  icache_size_sel,
  output wire        dcache_set0_en,
  output wire        dcache_set1_en,
  output wire [1:0]  dcache_set_size,
  output wire [3:0]  dcache_size_sel,
  output wire        inpage_write_en,
  output wire [1:0]  inpage_write_size,
  output wire [3:0]  inpage_size_sel,
  output wire        translation_en,
  output wire        unmapped_writeback_sel,
  output wire        dcache_set0_scratchpad,
  output wire        dcache_set1_scratchpad,
  output wire        cache_isolate,
  output wire        store_to_memory_en,
  output wire        tag_test_mode,
  output wire        cache_invalidate_mode
);
  reg  [31:0] config_cache_control_reg;
  wire [31:0] config_cache_control_next;
  wire        sel;

  assign sel = (cop_reg_num == `CCC_REG_NUM); // RL1
  // Reserved top bits never store, so they always read zero
  assign config_cache_control_next = (sel && cop_wr_en) ?
    (cop_wr_data & `CCC_WR_MASK) : config_cache_control_reg; // RL17

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      config_cache_control_reg <= `CCC_RESET_VAL; // RL2
    end else begin
      config_cache_control_reg <= config_cache_control_next; // RL18
    end
  end

  // Read data is registered; non-selected reads return zero
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cop_rd_data <= 32'h0000_0000;
    end else if (cop_rd_en) begin
      cop_rd_data <= sel ? config_cache_control_reg : 32'h0000_0000; // RL18
    end
  end

  assign ext_master_grant_en =
    config_cache_control_reg[`CCC_BIT_GRANT]; // RL3
  assign ext_master_grant = ext_master_req & ext_master_grant_en; // RL3
  assign icache_set0_en = config_cache_control_reg[`CCC_BIT_IE0]; // RL4
  assign icache_set1_en = config_cache_control_reg[`CCC_BIT_IE1]; // RL4
  assign icache_set_size =
    config_cache_control_reg[`CCC_IS_HI:`CCC_IS_LO]; // RL5
  assign dcache_set0_en = config_cache_control_reg[`CCC_BIT_DE0]; // RL6
  assign dcache_set1_en = config_cache_control_reg[`CCC_BIT_DE1]; // RL6
  assign dcache_set_size =
    config_cache_control_reg[`CCC_DS_HI:`CCC_DS_LO]; // RL7
  assign inpage_write_en = config_cache_control_reg[`CCC_BIT_INPAGE_WRITE_EN]; // RL8
  assign inpage_write_size =
    config_cache_control_reg[`CCC_IPWS_HI:`CCC_IPWS_LO]; // RL9
  assign translation_en = config_cache_control_reg[`CCC_BIT_TE]; // RL10
  assign unmapped_writeback_sel =
    config_cache_control_reg[`CCC_BIT_WB]; // RL11
  assign dcache_set0_scratchpad =
    config_cache_control_reg[`CCC_BIT_SR0]; // RL12
  assign dcache_set1_scratchpad =
    config_cache_control_reg[`CCC_BIT_SR1]; // RL12
  assign cache_isolate = config_cache_control_reg[`CCC_BIT_ISC]; // RL13
  assign store_to_memory_en = ~cache_isolate; // RL13
  assign tag_test_mode = config_cache_control_reg[`CCC_BIT_TAG]; // RL14
  // Caches are off at reset; software must clear tags first
  assign cache_invalidate_mode =
    config_cache_control_reg[`CCC_BIT_INV]; // RL15

  ccc_size_dec u_isize (
    .size_code   (icache_set_size),
    .size_onehot (icache_size_sel)
  ); // RL5
  ccc_size_dec u_dsize (
    .size_code   (dcache_set_size),
    .size_onehot (dcache_size_sel)
  ); // RL7
  ccc_size_dec u_psize (
    .size_code   (inpage_write_size),
    .size_onehot (inpage_size_sel)
  ); // RL9
endmodule // ccc_config_reg
`default_nettype wire

// [hw/ccc_defs.vh]
// Constants for the configuration and cache-control register.
// Assumes inclusion by bare name from design files under hw/.
`ifndef CCC_DEFS_VH
`define CCC_DEFS_VH
`define CCC_REG_NUM       5'h10
`define CCC_RESET_VAL     32'h0000_0000
`define CCC_WR_MASK       32'h0fff_ffff
`define CCC_BIT_GRANT     18
`define CCC_BIT_IE0       17
`define CCC_BIT_IE1       16
`define CCC_IS_HI         15
`define CCC_IS_LO         14
`define CCC_BIT_DE0       13
`define CCC_BIT_DE1       12
`define CCC_DS_HI         11
`define CCC_DS_LO         10
`define CCC_BIT_INPAGE_WRITE_EN      9
`define CCC_IPWS_HI       8
`define CCC_IPWS_LO       7
`define CCC_BIT_TE        6
`define CCC_BIT_WB        5
`define CCC_BIT_SR0       4
`define CCC_BIT_SR1       3
`define CCC_BIT_ISC       2
`define CCC_BIT_TAG       1
`define CCC_BIT_INV       0
`define CCC_SIZE_1K       2'h0
`define CCC_SIZE_2K       2'h1
`define CCC_SIZE_4K       2'h2
`define CCC_SIZE_8K       2'h3
`endif

// [hw/ccc_size_dec.v]
// Decodes a two-bit size code into a one-hot size select.
// Assumes the code comes from registered state on sys_clk.
`default_nettype none
`include "ccc_defs.vh"
module ccc_size_dec (
  input  wire [1:0] size_code,
  output reg  [3:0] size_onehot
);
  always @* begin
    case (size_code)
      `CCC_SIZE_1K: size_onehot = 4'h1;
      `CCC_SIZE_2K: size_onehot = 4'h2;
      `CCC_SIZE_4K: size_onehot = 4'h4;
      `CCC_SIZE_8K: size_onehot = 4'h8;
      default:      size_onehot = 4'h1;
    endcase
  end
endmodule // ccc_size_dec
`default_nettype wire

// [verif/ccc_config_reg_asserts.sv]
// Checker on the move strobes, read data and grant enable.
// Assumes the bind below attaches it to every ccc_config_reg.
`default_nettype none
module ccc_chk (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        cop_wr_en,
  input wire logic        cop_rd_en,
  input wire logic [4:0]  cop_reg_num,
  input wire logic [31:0] cop_wr_data,
  input wire logic [31:0] cop_rd_data,
  input wire logic        ext_master_grant_en
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_wr; cop_wr_en && cop_reg_num == 5'h10; endsequence
  sequence s_rd; cop_rd_en && cop_reg_num == 5'h10; endsequence
  property p_wr; s_wr |=> ext_master_grant_en == $past(cop_wr_data[18]);
  endproperty
  a_wr: assert property (p_wr) else $error("write lost");
  property p_hold; !cop_wr_en |=> $stable(ext_master_grant_en); endproperty
  a_hold: assert property (p_hold) else $error("bit moved");
  property p_rsv; cop_rd_en |=> cop_rd_data[31:28] == 4'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved set");
  property p_oth; cop_rd_en && cop_reg_num != 5'h10 |=>
    cop_rd_data == 32'h0000_0000; endproperty
  a_oth: assert property (p_oth) else $error("other read");
  property p_keep; !cop_rd_en |=> $stable(cop_rd_data); endproperty
  a_keep: assert property (p_keep) else $error("read moved");
  property p_rst; $rose(rst_n) |-> !ext_master_grant_en; endproperty
  a_rst: assert property (p_rst) else $error("not cleared");
  property p_rdd; s_rd |=> cop_rd_data[18] == $past(ext_master_grant_en);
  endproperty
  a_rdd: assert property (p_rdd) else $error("read stale");
  property p_wrd; s_wr ##1 !cop_wr_en ##1 s_rd |=>
    cop_rd_data == ($past(cop_wr_data, 3) & 32'h0fff_ffff); endproperty
  a_wrd: assert property (p_wrd) else $error("readback");
endmodule // ccc_chk
bind ccc_config_reg ccc_chk chk_u (.sys_clk, .rst_n, .cop_wr_en, .cop_rd_en,
  .cop_reg_num, .cop_wr_data, .cop_rd_data, .ext_master_grant_en);
`default_nettype wire

// [verif/ccc_config_reg_test.sv]
// Bench: drives the move strobes itself and judges each output.
// Assumes the bound checker file is compiled with it.
`default_nettype none
module ccc_config_reg_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 0, rst_n = 0, cop_wr_en = 0, cop_rd_en = 0;
  logic ext_master_req = 1, ext_master_grant;
  logic [4:0] cop_reg_num = 5'h10;
  logic [31:0] cop_wr_data = 0, cop_rd_data, e;
  wire logic [19:0] o;
  wire logic [11:0] sz;
  int num_errors = 0, n_compared = 0, cyc = 0;
  ccc_config_reg dut_u (.sys_clk(sys_clk), .rst_n(rst_n),
    .cop_wr_en(cop_wr_en), .cop_rd_en(cop_rd_en),
    .cop_reg_num(cop_reg_num), .cop_wr_data(cop_wr_data),
    .cop_rd_data(cop_rd_data), .ext_master_req(ext_master_req),
    .ext_master_grant(ext_master_grant), .store_to_memory_en(o[19]),
    .ext_master_grant_en(o[18]), .icache_set0_en(o[17]),
    .icache_set1_en(o[16]), .icache_set_size(o[15:14]),
    .dcache_set0_en(o[13]), .dcache_set1_en(o[12]),
    .dcache_set_size(o[11:10]), .inpage_write_en(o[9]),
    .inpage_write_size(o[8:7]), .translation_en(o[6]),
    .unmapped_writeback_sel(o[5]), .dcache_set0_scratchpad(o[4]),
    .dcache_set1_scratchpad(o[3]), .cache_isolate(o[2]),
    .tag_test_mode(o[1]), .cache_invalidate_mode(o[0]),
    .icache_size_sel(sz[11:8]), .dcache_size_sel(sz[7:4]),
    .inpage_size_sel(sz[3:0]));
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (++cyc == 1000) begin
    num_errors++;
    finish_test();
  end
  // One-hot size select expected for a two-bit size code
  function logic [3:0] oh(input logic [1:0] c);
    return 4'h1 << c;
  endfunction
  task chk(input logic [31:0] s, x);
    n_compared++;
    if (s !== x) begin
      num_errors++;
      $display("unexpected at %0t: %h not %h", $time, s, x);
    end
  endtask
  task wr(input logic [4:0] n, input logic [31:0] d, v);
    @(posedge sys_clk) {cop_wr_en, cop_reg_num, cop_wr_data} <= {1'b1, n, d};
    @(posedge sys_clk) cop_wr_en <= 0;
    #1 chk(o, {~v[2], v[18:0]});
    chk(ext_master_grant, ext_master_req & v[18]);
    chk(sz, {oh(v[15:14]), oh(v[11:10]), oh(v[8:7])});
  endtask
  task rd(input logic [4:0] n, input logic [31:0] x);
    @(posedge sys_clk) {cop_rd_en, cop_reg_num} <= {1'b1, n};
    @(posedge sys_clk) cop_rd_en <= 0;
    #1 chk(cop_rd_data, x);
  endtask
  task t_reset;
    #1 chk(o, 20'h8_0000);
    chk(sz, 12'h111);
    rd(5'h10, 0);
    wr(5'h10, 32'h1, 32'h1);
  endtask
  // Walking one: any bit landing on the wrong output shows here
  task t_walk;
    for (int i = 0; i < 32; i++) begin
      e = 32'h1 << i;
      wr(5'h10, e, e & 32'h0fff_ffff);
      rd(5'h10, e & 32'h0fff_ffff);
    end
  endtask
  task t_misc;
    wr(5'h10, '1, 32'h0fff_ffff);
    wr(5'h11, 0, 32'h0fff_ffff);
    rd(5'h11, 0);
    @(posedge sys_clk) begin
      {cop_wr_en, cop_rd_en, cop_reg_num} <= {2'b11, 5'h10};
      {cop_wr_data, ext_master_req} <= {32'h0000_0000, 1'b0};
    end
    @(posedge sys_clk) {cop_wr_en, cop_rd_en} <= 2'b00;
    #1 chk(cop_rd_data, 32'h0fff_ffff);
    chk(ext_master_grant, 0);
    rd(5'h10, 0);
  endtask
  // Mid-run reset must clear a fully written register
  task t_rerun;
    wr(5'h10, 32'hffff_ffff, 32'h0fff_ffff);
    @(posedge sys_clk) rst_n <= 0;
    #1 chk(o, 20'h8_0000);
    chk(sz, 12'h111);
    @(posedge sys_clk) rst_n <= 1;
    rd(5'h10, 0);
  endtask
  task finish_test;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge sys_clk);
    rst_n <= 1;
    t_reset;
    t_walk;
    t_misc;
    t_rerun;
    finish_test();
  end
endmodule // ccc_config_reg_test
`default_nettype wire
